//--- common/sis_pkg.sv
// Shared constants and types for the sheet inspection I/O sequencer
package sis_pkg;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SIS_IDLE    = 3'b000,
    SIS_CAPTURE = 3'b001,
    SIS_EVAL    = 3'b010,
    SIS_LEARN   = 3'b011,
    SIS_PICK    = 3'b100
  } sis_state_e;

  // ----------------------------------------------------------------
  // Comparison modes
  // ----------------------------------------------------------------
  localparam logic [1:0] SIS_MODE_IMAGE = 2'h0;
  localparam logic [1:0] SIS_MODE_GRAY = 2'h1;
  localparam logic [1:0] SIS_MODE_BARCODE = 2'h2;

  // ----------------------------------------------------------------
  // Network framing
  // ----------------------------------------------------------------
  localparam logic [15:0] SIS_NET_PORT = 16'hC355;
  localparam int SIS_PRE_LEN = 12;
  localparam logic [3:0] SIS_SIZE_FIRST = 4'h8;
  localparam logic [15:0] SIS_PRE_MAGIC = 16'h5046;
  localparam logic [15:0] SIS_PRE_VERSION = 16'h0001;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic SIS_MODE_OUT_RST = 1'b1;
  localparam logic [3:0] SIS_CNT_RST = 4'h0;

endpackage : sis_pkg

//--- verilog/sis_edge.sv
// Two-stage synchroniser with rising and falling edge detection
`timescale 1ns/10ps
`default_nettype none
module sis_edge
  import sis_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_din,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);

  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  // Next values of the synchroniser chain
  always_comb
  begin
    next_meta = i_din;
    next_sync = meta;
    next_prev = sync;
  end

  // Register chain
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  // Edge pulses use only the second and third stages
  assign o_level = sync;
  assign o_rise = sync & ~prev;
  assign o_fall = ~sync & prev;

endmodule : sis_edge
`default_nettype wire

//--- verilog/sis_prehdr.sv
// Serialiser of the 12-byte network pre-header with 32-bit size field
`timescale 1ns/10ps
`default_nettype none
module sis_prehdr
  import sis_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [15:0] i_type,
  input wire logic [15:0] i_status,
  input wire logic [31:0] i_size,
  input wire logic i_ready,
  output logic o_valid,
  output logic [7:0] o_byte,
  output logic o_last,
  output logic o_busy
);

  logic busy;
  logic [3:0] idx;
  logic [95:0] hdr;
  logic next_busy;
  logic [3:0] next_idx;
  logic [95:0] next_hdr;

  // Fixed-length header, data length last, big endian
  always_comb
  begin
    next_busy = busy;
    next_idx = idx;
    next_hdr = hdr;
    if (!busy && i_start)
    begin
      next_busy = 1'b1;
      next_idx = SIS_CNT_RST;
      next_hdr = {SIS_PRE_MAGIC, SIS_PRE_VERSION, i_type, i_status, i_size};
    end
    else if (busy && i_ready)
    begin
      next_hdr = {hdr[87:0], 8'h00};
      next_idx = idx + 4'h1;
      if (idx == 4'(SIS_PRE_LEN - 1))
        next_busy = 1'b0;
    end
  end

  // Header registers
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      busy <= 1'b0;
      idx <= SIS_CNT_RST;
      hdr <= 96'h0;
    end
    else
    begin
      busy <= next_busy;
      idx <= next_idx;
      hdr <= next_hdr;
    end
  end

  assign o_valid = busy;
  assign o_byte = hdr[95:88];
  assign o_last = busy && (idx == 4'(SIS_PRE_LEN - 1));
  assign o_busy = busy;

endmodule : sis_prehdr
`default_nettype wire

//--- verilog/sis_sequencer.sv
// Capture, evaluation and teach-in sequencer of the sheet inspection sensor
// How it works
// - Each trigger rising edge in inspection while the sequencer is idle captures one image, then inspects it.
// - Strobe output goes high when evaluation of the image is finished.
// - In inspection, result output low on fail, high on pass.
// - Image mode compares each later sheet with the stored pattern.
// - During learning, a trigger edge captures and stores the pattern image.
// - Learning trigger captures one or several images per learning sub-mode.
// - With several learning images, the best one becomes the pattern.
// - Strobe output high marks the end of learning.
// - After learning, result high on success; else low, gray mode used.
// - Barcode mode passes only on decoded code equal to stored code.
// - Network traffic uses TCP/IP on service port 50005.
// - Each packet is a 12-byte pre-header then variable data.
// - Mode output high in inspection, low in learning.
// - Pre-header ends with 32-bit byte length of the data.
`timescale 1ns/10ps
`default_nettype none
module sis_sequencer
  import sis_pkg::*;
#(
  parameter int CODE_W = 32,
  parameter int SCORE_W = 8
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_trigger,
  input wire logic i_teach,
  input wire logic i_net_teach,
  input wire logic i_net_trigger,
  input wire logic i_barcode_en,
  input wire logic [3:0] i_learn_count,
  input wire logic [SCORE_W-1:0] i_pass_level,
  input wire logic [CODE_W-1:0] i_stored_code,
  output logic o_cap_req,
  input wire logic i_cap_done,
  input wire logic [SCORE_W-1:0] i_cap_score,
  input wire logic i_cap_learnable,
  input wire logic i_code_valid,
  input wire logic [CODE_W-1:0] i_code,
  output logic o_store_pat,
  output logic [3:0] o_store_index,
  output logic o_strobe,
  output logic o_result,
  output logic o_mode,
  output logic [1:0] o_cmp_mode,
  input wire logic [31:0] i_tx_size,
  input wire logic [15:0] i_tx_type,
  input wire logic [15:0] i_tx_status,
  input wire logic i_tx_start,
  input wire logic i_tx_ready,
  output logic o_tx_valid,
  output logic [7:0] o_tx_byte,
  output logic o_tx_last,
  output logic [15:0] o_tx_port
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic trig_rise;
  logic teach_level;
  logic teach_rise;

  // Trigger edge detection
  sis_edge u_trig (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_din(i_trigger),
    .o_level(),
    .o_rise(trig_rise),
    .o_fall()
  );

  // Teach line synchronisation
  sis_edge u_teach (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_din(i_teach),
    .o_level(teach_level),
    .o_rise(teach_rise),
    .o_fall()
  );

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  sis_state_e state;
  sis_state_e next_state;
  logic learning;
  logic next_learning;
  logic net_learn;
  logic next_net_learn;
  logic [3:0] shots;
  logic [3:0] next_shots;
  logic [3:0] best_idx;
  logic [3:0] next_best_idx;
  logic [SCORE_W-1:0] best_score;
  logic [SCORE_W-1:0] next_best_score;
  logic best_ok;
  logic next_best_ok;
  logic cap_req;
  logic next_cap_req;
  logic store_pat;
  logic next_store_pat;
  logic [3:0] store_index;
  logic [3:0] next_store_index;
  logic strobe;
  logic next_strobe;
  logic result;
  logic next_result;
  logic gray_mode;
  logic next_gray_mode;
  logic mode;
  logic next_mode;

  logic trig_any;
  logic [3:0] want;

  assign trig_any = trig_rise | i_net_trigger;
  assign want = (i_learn_count == 4'h0) ? 4'h1 : i_learn_count;

  // Verdict for one inspected image, by comparison mode
  function automatic logic verdict(
    input logic bc_en,
    input logic [SCORE_W-1:0] score,
    input logic [SCORE_W-1:0] lvl,
    input logic code_ok,
    input logic [CODE_W-1:0] code,
    input logic [CODE_W-1:0] ref_code
  );
    if (bc_en)
      verdict = code_ok && (code == ref_code);
    else
      verdict = (score >= lvl);
  endfunction : verdict

  // Next-state and output computation
  always_comb
  begin
    next_state = state;
    next_learning = learning;
    next_net_learn = net_learn;
    next_shots = shots;
    next_best_idx = best_idx;
    next_best_score = best_score;
    next_best_ok = best_ok;
    next_cap_req = 1'b0;
    next_store_pat = 1'b0;
    next_store_index = store_index;
    next_strobe = strobe;
    next_result = result;
    next_gray_mode = gray_mode;
    // Learning starts on teach level or network command
    if (teach_rise || i_net_teach)
      next_net_learn = i_net_teach | net_learn;
    case (state)
      SIS_IDLE:
      begin
        if ((teach_level || next_net_learn) && !learning)
          next_learning = 1'b1;
        else if (learning && !teach_level && !net_learn)
          next_learning = 1'b0;
        if (trig_any)
        begin
          next_strobe = 1'b0;
          next_cap_req = 1'b1;
          next_shots = 4'h0;
          next_best_score = '0;
          next_best_ok = 1'b0;
          next_best_idx = 4'h0;
          if (learning)
            next_state = SIS_LEARN;
          else
            next_state = SIS_CAPTURE;
        end
      end
      SIS_CAPTURE:
      begin
        // Capture results are only valid in the done cycle
        if (i_cap_done)
        begin
          next_result = gray_mode && !i_barcode_en
                      ? (i_cap_score >= i_pass_level)
                      : verdict(i_barcode_en, i_cap_score, i_pass_level,
                                i_code_valid, i_code, i_stored_code);
          next_state = SIS_EVAL;
        end
      end
      SIS_EVAL:
      begin
        next_strobe = 1'b1;
        next_state = SIS_IDLE;
      end
      SIS_LEARN:
      begin
        if (i_cap_done)
        begin
          // Keep the best candidate seen so far
          if (i_cap_learnable && (!best_ok || i_cap_score > best_score))
          begin
            next_best_ok = 1'b1;
            next_best_score = i_cap_score;
            next_best_idx = shots;
          end
          next_shots = shots + 4'h1;
          if (shots + 4'h1 >= want)
            next_state = SIS_PICK;
          else
            next_cap_req = 1'b1;
        end
      end
      SIS_PICK:
      begin
        next_store_pat = 1'b1;
        next_store_index = best_idx;
        next_result = best_ok;
        next_gray_mode = !best_ok;
        next_strobe = 1'b1;
        next_net_learn = i_net_teach; // New command wins over the clear
        next_state = SIS_IDLE;
      end
      default:
      begin
        next_state = SIS_IDLE;
      end
    endcase
    next_mode = ~next_learning;
  end

  // Sequencer registers
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      state <= SIS_IDLE;
      learning <= 1'b0;
      net_learn <= 1'b0;
      shots <= SIS_CNT_RST;
      best_idx <= SIS_CNT_RST;
      best_score <= '0;
      best_ok <= 1'b0;
      cap_req <= 1'b0;
      store_pat <= 1'b0;
      store_index <= SIS_CNT_RST;
      strobe <= 1'b0;
      result <= 1'b0;
      gray_mode <= 1'b0;
      mode <= SIS_MODE_OUT_RST;
    end
    else
    begin
      state <= next_state;
      learning <= next_learning;
      net_learn <= next_net_learn;
      shots <= next_shots;
      best_idx <= next_best_idx;
      best_score <= next_best_score;
      best_ok <= next_best_ok;
      cap_req <= next_cap_req;
      store_pat <= next_store_pat;
      store_index <= next_store_index;
      strobe <= next_strobe;
      result <= next_result;
      gray_mode <= next_gray_mode;
      mode <= next_mode;
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  assign o_cap_req = cap_req;
  assign o_store_pat = store_pat;
  assign o_store_index = store_index;
  assign o_strobe = strobe;
  assign o_result = result;
  assign o_mode = mode;
  assign o_cmp_mode = i_barcode_en ? SIS_MODE_BARCODE
                    : (gray_mode ? SIS_MODE_GRAY : SIS_MODE_IMAGE);
  assign o_tx_port = SIS_NET_PORT;

  // ----------------------------------------------------------------
  // Network pre-header framing
  // ----------------------------------------------------------------
  logic [7:0] tx_byte;
  logic tx_valid;
  logic tx_last;
  logic [7:0] tx_byte_q;
  logic tx_valid_q;
  logic tx_last_q;

  // Header serialiser, size field last
  sis_prehdr u_hdr (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_start(i_tx_start),
    .i_type(i_tx_type),
    .i_status(i_tx_status),
    .i_size(i_tx_size),
    .i_ready(i_tx_ready),
    .o_valid(tx_valid),
    .o_byte(tx_byte),
    .o_last(tx_last),
    .o_busy()
  );

  // Header byte stream registered toward the network stack
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      tx_byte_q <= 8'h00;
      tx_valid_q <= 1'b0;
      tx_last_q <= 1'b0;
    end
    else
    begin
      tx_byte_q <= tx_byte;
      tx_valid_q <= tx_valid & i_tx_ready;
      tx_last_q <= tx_last & i_tx_ready;
    end
  end

  assign o_tx_byte = tx_byte_q;
  assign o_tx_valid = tx_valid_q;
  assign o_tx_last = tx_last_q;

endmodule : sis_sequencer
`default_nettype wire

//--- test/sis_seq_sva.sv
// Port checker of the sheet inspection sequencer
`timescale 1ns/10ps
`default_nettype none
module sis_seq_sva
  import sis_pkg::*;
#(
  parameter int CODE_W = 32,
  parameter int SCORE_W = 8
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_trigger,
  input wire logic i_cap_done,
  input wire logic [SCORE_W-1:0] i_cap_score,
  input wire logic [SCORE_W-1:0] i_pass_level,
  input wire logic i_code_valid,
  input wire logic [CODE_W-1:0] i_code,
  input wire logic [CODE_W-1:0] i_stored_code,
  input wire logic [3:0] i_learn_count,
  input wire logic i_tx_ready,
  input wire logic o_cap_req,
  input wire logic o_store_pat,
  input wire logic [3:0] o_store_index,
  input wire logic o_strobe,
  input wire logic o_result,
  input wire logic o_mode,
  input wire logic [1:0] o_cmp_mode,
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_byte,
  input wire logic o_tx_last,
  input wire logic [15:0] o_tx_port
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  // Counts header bytes taken by the sink
  logic [3:0] nb;
  logic [3:0] next_nb;
  always_comb
  begin
    next_nb = nb;
    if (o_tx_valid)
      next_nb = o_tx_last ? 4'h0 : nb + 4'h1;
  end
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      nb <= 4'h0;
    else
      nb <= next_nb;
  end

  // Port relations
  property p_port; o_tx_port == 16'hC355; endproperty
  a_port: assert property (p_port) else $error("service port wrong");
  property p_rst; $rose(i_rst_n) |-> o_mode && !o_strobe; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_trig; $rose(i_trigger) && o_strobe |-> ##[2:6] o_cap_req;
  endproperty
  a_trig: assert property (p_trig) else $error("no capture");
  property p_done; o_mode && i_cap_done |-> ##2 o_strobe; endproperty
  a_done: assert property (p_done) else $error("no strobe");
  property p_img;
    o_mode && i_cap_done && o_cmp_mode != SIS_MODE_BARCODE ##2 1 |->
      o_result == ($past(i_cap_score, 2) >= $past(i_pass_level, 2));
  endproperty
  a_img: assert property (p_img) else $error("image verdict");
  property p_code;
    o_mode && i_cap_done && o_cmp_mode == SIS_MODE_BARCODE ##2 1 |->
      o_result == ($past(i_code_valid, 2) &&
      $past(i_code, 2) == $past(i_stored_code, 2));
  endproperty
  a_code: assert property (p_code) else $error("code verdict");
  property p_store;
    o_store_pat |-> !$past(o_mode, 2) &&
      (o_store_index < i_learn_count || o_store_index == 4'h0);
  endproperty
  a_store: assert property (p_store) else $error("bad store");
  property p_frame;
    o_tx_valid |-> (o_tx_last == (nb == 4'hB)) &&
      (nb != 4'h0 || o_tx_byte == 8'h50);
  endproperty
  a_frame: assert property (p_frame) else $error("bad header");
  c_store: cover property (o_store_pat);
  c_code: cover property (o_mode && o_cmp_mode == SIS_MODE_BARCODE);
  c_last: cover property (o_tx_valid && o_tx_last);
endmodule : sis_seq_sva

bind sis_sequencer sis_seq_sva #(.CODE_W(CODE_W), .SCORE_W(SCORE_W)) u_sva (
  .i_clk_sys, .i_rst_n, .i_trigger, .i_cap_done, .i_cap_score, .i_pass_level,
  .i_code_valid, .i_code, .i_stored_code, .i_learn_count, .i_tx_ready,
  .o_cap_req, .o_store_pat, .o_store_index, .o_strobe, .o_result, .o_mode,
  .o_cmp_mode, .o_tx_valid, .o_tx_byte, .o_tx_last, .o_tx_port);
`default_nettype wire

//--- test/sis_cam_model.sv
// Model of the image capture and analysis unit
`timescale 1ns/10ps
`default_nettype none
module sis_cam_model
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_cap_req,
  input wire logic [4:0] i_delay,
  input wire logic [7:0] i_sc [16],
  input wire logic i_ln [16],
  input wire logic i_cv,
  input wire logic [31:0] i_code,
  output logic o_done,
  output logic [7:0] o_score,
  output logic o_learnable,
  output logic o_code_valid,
  output logic [31:0] o_code,
  output logic [3:0] o_idx
);
  logic busy = 1'b0;
  logic [4:0] cnt = 5'h0;
  logic [7:0] tick = 8'h0;
  initial
  begin
    o_done = 1'b0;
    o_code = 32'h0;
    o_idx = 4'h0;
  end
  // One capture at a time; outside the done cycle the data churns
  always @(posedge i_clk_sys)
  begin
    tick <= tick + 8'h1;
    o_done <= 1'b0;
    o_score <= tick;
    o_learnable <= tick[0];
    o_code_valid <= tick[1];
    o_code <= ~o_code;
    if (!i_rst_n)
    begin
      busy <= 1'b0;
      o_idx <= 4'h0;
    end
    else if (busy && cnt != 5'h0)
      cnt <= cnt - 5'h1;
    else if (busy)
    begin
      busy <= 1'b0;
      o_done <= 1'b1;
      o_score <= i_sc[o_idx];
      o_learnable <= i_ln[o_idx];
      o_code_valid <= i_cv;
      o_code <= i_code;
      o_idx <= o_idx + 4'h1;
    end
    else if (i_cap_req)
    begin
      busy <= 1'b1;
      cnt <= i_delay;
    end
  end
endmodule : sis_cam_model
`default_nettype wire

//--- test/tb.sv
// Self-checking bench of the sheet inspection sequencer
`timescale 1ns/10ps
`default_nettype none
module tb
  import sis_pkg::*;
;
  logic i_clk_sys = 1'b0, i_rst_n = 1'b0, i_trigger = 1'b0, i_teach = 1'b0;
  logic i_net_teach = 1'b0, i_net_trigger = 1'b0, i_barcode_en = 1'b0;
  logic i_tx_start = 1'b0, i_tx_ready = 1'b0, cv = 1'b0;
  logic [3:0] i_learn_count = 4'h1;
  logic [7:0] i_pass_level = 8'h80;
  logic [31:0] i_stored_code = 32'h0, i_tx_size = 32'h0, code = 32'h0;
  logic [15:0] i_tx_type = 16'h0, i_tx_status = 16'h0, o_tx_port;
  logic o_cap_req, i_cap_done, i_cap_learnable, i_code_valid, o_store_pat;
  logic o_strobe, o_result, o_mode, o_tx_valid, o_tx_last;
  logic [7:0] i_cap_score, o_tx_byte;
  logic [7:0] sc [16];
  logic ln [16];
  logic [31:0] i_code;
  logic [3:0] o_store_index, cam_idx, st_idx;
  logic [1:0] o_cmp_mode;
  logic [4:0] dly = 5'h0;
  int error_cnt = 0, check_count = 0, seed = 92480, cyc_n = 0, stores = 0;

  sis_sequencer u_sis_sequencer (.i_clk_sys, .i_rst_n, .i_trigger, .i_teach,
    .i_net_teach, .i_net_trigger, .i_barcode_en, .i_learn_count,
    .i_pass_level, .i_stored_code, .o_cap_req, .i_cap_done, .i_cap_score,
    .i_cap_learnable, .i_code_valid, .i_code, .o_store_pat, .o_store_index,
    .o_strobe, .o_result, .o_mode, .o_cmp_mode, .i_tx_size, .i_tx_type,
    .i_tx_status, .i_tx_start, .i_tx_ready, .o_tx_valid, .o_tx_byte,
    .o_tx_last, .o_tx_port);
  sis_cam_model u_cam (.i_clk_sys, .i_rst_n, .i_cap_req(o_cap_req),
    .i_delay(dly), .i_sc(sc), .i_ln(ln), .i_cv(cv), .i_code(code),
    .o_done(i_cap_done), .o_score(i_cap_score), .o_learnable(i_cap_learnable),
    .o_code_valid(i_code_valid), .o_code(i_code), .o_idx(cam_idx));

  always #12.5 i_clk_sys = ~i_clk_sys;
  // Sink stalls at random
  always @(posedge i_clk_sys) i_tx_ready <= 1'($random(seed));
  // Store pulses seen, and the hang limit
  always @(negedge i_clk_sys)
  begin
    if (o_store_pat === 1'b1)
    begin
      stores++;
      st_idx = o_store_index;
    end
    cyc_n++;
    if (cyc_n == 30000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  // Compare one value
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (e !== g)
    begin
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
      error_cnt++;
    end
  endtask : chk

  // Print the verdict and stop
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // One trigger; count captures until the strobe comes
  task automatic fire(input int ncap, input bit net);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    if (net)
      i_net_trigger <= 1'b1;
    else
      i_trigger <= 1'b1;
    @(posedge i_clk_sys);
    i_net_trigger <= 1'b0;
    for (int t = 0; t < 400 && !(n == ncap && o_strobe === 1'b1); t++)
    begin
      @(negedge i_clk_sys);
      if (o_cap_req === 1'b1)
        n++;
    end
    @(posedge i_clk_sys);
    i_trigger <= 1'b0;
    chk("captures", ncap, n);
  endtask : fire

  // One inspection against the reckoned verdict
  task automatic insp(input bit net);
    logic [7:0] s;
    logic [7:0] lv;
    logic e;
    s = 8'($random(seed));
    lv = 8'($random(seed));
    for (int j = 0; j < 16; j++)
      sc[j] = s;
    dly = 5'($random(seed));
    e = i_barcode_en ? (cv && code == i_stored_code) : (s >= lv);
    @(posedge i_clk_sys);
    i_pass_level <= lv;
    fire(1, net);
    @(negedge i_clk_sys);
    chk("strobe", 1, o_strobe);
    chk("result", e, o_result);
  endtask : insp

  // Teach-in; best learnable image of the set is expected
  task automatic learn(input int cnt, input bit net, input bit ok);
    int n;
    int best;
    int bi;
    int s0;
    best = -1;
    bi = 0;
    for (int j = 0; j < 16; j++)
    begin
      sc[cam_idx + 4'(j)] = 8'(((j * 7) % 16) * 16 + ($random(seed) & 15));
      ln[cam_idx + 4'(j)] = ok & 1'($random(seed));
    end
    if (ok)
      ln[cam_idx] = 1'b1;
    n = (cnt == 0) ? 1 : cnt;
    for (int j = 0; j < n; j++)
      if (ln[cam_idx + 4'(j)] && int'(sc[cam_idx + 4'(j)]) > best)
      begin
        best = sc[cam_idx + 4'(j)];
        bi = j;
      end
    @(posedge i_clk_sys);
    i_learn_count <= 4'(cnt);
    if (net)
      i_net_teach <= 1'b1;
    else
      i_teach <= 1'b1;
    @(posedge i_clk_sys);
    i_net_teach <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk("mode", 0, o_mode);
    s0 = stores;
    fire(n, 1'b0);
    @(negedge i_clk_sys);
    chk("stores", s0 + 1, stores);
    if (ok)
      chk("index", bi, st_idx);
    chk("strobe", 1, o_strobe);
    chk("result", ok, o_result);
    @(posedge i_clk_sys);
    i_teach <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk("mode", 1, o_mode);
    chk("cmode", ok ? SIS_MODE_IMAGE : SIS_MODE_GRAY, o_cmp_mode);
  endtask : learn

  // One header frame; bytes collected as the sink takes them
  task automatic frame(input int k);
    logic [95:0] hdr;
    logic [7:0] got[$];
    int lastpos;
    hdr = {16'h5046, 16'h0001, 13'h0, 3'($random(seed)) + 3'h1,
      2'(k), 14'h0, 32'($random(seed))};
    @(posedge i_clk_sys);
    {i_tx_type, i_tx_status, i_tx_size} <= hdr[63:0];
    i_tx_start <= 1'b1;
    @(posedge i_clk_sys);
    i_tx_start <= 1'b0;
    lastpos = -1;
    for (int t = 0; t < 300 && lastpos < 0; t++)
    begin
      @(negedge i_clk_sys);
      if (o_tx_valid === 1'b1)
      begin
        got.push_back(o_tx_byte);
        if (o_tx_last === 1'b1)
          lastpos = got.size() - 1;
      end
    end
    chk("last", 11, lastpos);
    for (int j = 0; j < 12; j++)
      chk("byte", hdr[95 - 8 * j -: 8], got[j]);
    repeat (4) @(posedge i_clk_sys);
  endtask : frame

  // Reset, then each scenario in turn
  initial
  begin
    for (int j = 0; j < 16; j++)
    begin
      sc[j] = 8'h00;
      ln[j] = 1'b0;
    end
    repeat (4) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(negedge i_clk_sys);
    chk("mode", 1, o_mode);
    chk("port", 16'hC355, o_tx_port);
    repeat (6) insp(1'b0);
    dly = 5'h1F;
    @(posedge i_clk_sys);
    i_trigger <= 1'b1;
    repeat (10) @(posedge i_clk_sys);
    i_trigger <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    fire(0, 1'b0);
    for (int j = 0; j < 3; j++)
    begin
      @(posedge i_clk_sys);
      i_barcode_en <= 1'b1;
      i_stored_code <= $random(seed);
      @(negedge i_clk_sys);
      cv = (j != 2);
      code = i_stored_code ^ 32'(j == 1);
      insp(1'b0);
      chk("cmode", SIS_MODE_BARCODE, o_cmp_mode);
    end
    @(posedge i_clk_sys);
    i_barcode_en <= 1'b0;
    learn(3, 1'b0, 1'b1);
    learn(0, 1'b0, 1'b0);
    repeat (2) insp(1'b1);
    learn(1, 1'b1, 1'b1);
    insp(1'b0);
    for (int k = 0; k < 3; k++)
      frame(k);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
